/* inc/scan_regs_pkg.sv */
package scan_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE = 6'h02;
  localparam logic [5:0] IDX_TOP = 6'h03;
  localparam logic [5:0] IDX_BOT = 6'h04;
  localparam logic [5:0] IDX_DUTY = 6'h05;
  localparam logic [5:0] IDX_RAMP = 6'h06;
  localparam logic [5:0] IDX_RAMP_CUR = 6'h07;
  localparam logic [5:0] IDX_VDAC_MAX = 6'h08;
  localparam logic [5:0] IDX_BIAS = 6'h09;

  // field positions
  localparam int STEREO_BIT = 4;
  localparam int SCAN_HI_BIT = 3;
  localparam int SCAN_LO_BIT = 2;
  localparam int VDIR_BIT = 1;
  localparam int HDIR_BIT = 0;
  localparam int POS_HI_BIT = 5;
  localparam int PSAVE_BIT = 4;
  localparam int RAMP_HIGH_BIT = 3;

  // writable bits; the rest read as zero
  localparam logic [7:0] MODE_MASK = 8'h1f;
  localparam logic [7:0] POS_MASK = 8'h3f;
  localparam logic [7:0] FULL_MASK = 8'hff;

  // values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] TOP_RESET = 8'h0e;
  localparam logic [7:0] BOT_RESET = 8'h0e;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] RAMP_RESET = 8'h00;
  localparam logic [7:0] RAMP_CUR_RESET = 8'h00;
  localparam logic [7:0] VDAC_MAX_RESET = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SCAN_PROGRESSIVE = 2'b00,
    SCAN_INTERLACED = 2'b01,
    SCAN_PSEUDO = 2'b10
  } scan_type_e;

  typedef struct packed {
    logic stereo_sequence_select;
    scan_type_e scan_type_select;
    logic vertical_direction;
    logic horizontal_direction;
    logic [5:0] top_row_position;
    logic [5:0] bottom_row_position;
  } scan_cfg_s;

  localparam scan_cfg_s CFG_RESET = '{
    stereo_sequence_select: 1'b0,
    scan_type_select: SCAN_PROGRESSIVE,
    vertical_direction: 1'b0,
    horizontal_direction: 1'b0,
    top_row_position: 6'h0e,
    bottom_row_position: 6'h0e
  };

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [9:2][7:0] regs;
    scan_cfg_s active;
    logic [8:0] line_cnt;
    logic row_reset;
    logic [7:0] ramp_code;
  } state_s;

endpackage : scan_regs_pkg

/* hdl/microdisplay_scan_ctrl_regs.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

// Function
// RULE1 - mode bit 4 selects stereo sequence
// RULE2 - bits 3-2 pick progressive, interlaced, pseudo
// RULE3 - bit 1 sets vertical row direction
// RULE4 - bit 0 sets horizontal pixel direction
// RULE5 - six-bit top row, reset 14
// RULE6 - six-bit bottom row, reset 14
// RULE7 - rows lit twice duty lines; zero disables
// RULE8 - ramp bit 4 enables counter power save
// RULE9 - ramp high bit forces DAC code ones
// RULE10 - scan settings apply at next frame start
module microdisplay_scan_ctrl_regs (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [scan_regs_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [scan_regs_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [scan_regs_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [scan_regs_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // video timing, same clock
  input wire logic FRAME_START,
  input wire logic LINE_START,
  input wire logic [7:0] RAMP_CODE_IN,
  // settings to the video and ramp logic
  output scan_regs_pkg::scan_cfg_s SCAN_CFG,
  output logic ROW_DUTY_EN,
  output logic ROW_RESET,
  output logic COUNTER_POWER_SAVE,
  output logic [7:0] RAMP_DAC_CODE,
  output logic [7:0] RAMP_CURRENT,
  output logic [7:0] VDAC_MAX,
  output logic [7:0] BIAS
);

  scan_regs_pkg::state_s s_reg;
  scan_regs_pkg::state_s s_next;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_commit;
  logic [7:0] mode_now;
  logic [7:0] duty_now;
  // nine bits hold twice the largest duty value
  logic [8:0] duty_lines;

  function automatic logic [5:0] word_index(input logic [scan_regs_pkg::ADDR_W-1:0] a);
    word_index = a[scan_regs_pkg::ADDR_W-1:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [scan_regs_pkg::ADDR_W-1:0] a);
    logic [5:0] i;
    i = a[scan_regs_pkg::ADDR_W-1:2];
    is_mapped = (a[1:0] == 2'h0) && (i >= scan_regs_pkg::IDX_MODE) &&
                (i <= scan_regs_pkg::IDX_BIAS);
  endfunction : is_mapped

  function automatic logic [7:0] write_mask(input logic [5:0] i);
    case (i)
      scan_regs_pkg::IDX_MODE: write_mask = scan_regs_pkg::MODE_MASK;
      scan_regs_pkg::IDX_TOP: write_mask = scan_regs_pkg::POS_MASK;
      scan_regs_pkg::IDX_BOT: write_mask = scan_regs_pkg::POS_MASK;
      default: write_mask = scan_regs_pkg::FULL_MASK;
    endcase
  endfunction : write_mask

  // an upper scan bit means pseudo-interlaced whatever the lower bit says
  function automatic scan_regs_pkg::scan_type_e scan_decode(input logic [1:0] f);
    if (f[1]) begin
      scan_decode = scan_regs_pkg::SCAN_PSEUDO; // RULE2
    end else if (f[0]) begin
      scan_decode = scan_regs_pkg::SCAN_INTERLACED;
    end else begin
      scan_decode = scan_regs_pkg::SCAN_PROGRESSIVE;
    end
  endfunction : scan_decode

  assign wr_idx = word_index(s_reg.aw_addr);
  assign rd_idx = word_index(S_AXI_ARADDR);
  assign wr_commit = s_reg.aw_full && s_reg.w_full;
  assign mode_now = s_reg.regs[scan_regs_pkg::IDX_MODE];
  assign duty_now = s_reg.regs[scan_regs_pkg::IDX_DUTY];
  assign duty_lines = {duty_now, 1'b0};

  // no new write is taken while a response waits, so one write is open at a time
  assign S_AXI_AWREADY = !s_reg.aw_full && !s_reg.bvalid;
  assign S_AXI_WREADY = !s_reg.w_full && !s_reg.bvalid;
  assign S_AXI_ARREADY = !s_reg.rvalid;

  always_comb begin
    s_next = s_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_next.w_full = 1'b1;
      s_next.w_data = S_AXI_WDATA;
      s_next.w_strb = S_AXI_WSTRB;
    end
    if (s_reg.bvalid && S_AXI_BREADY) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_commit) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = scan_regs_pkg::RESP_SLVERR;
      if (is_mapped(s_reg.aw_addr)) begin
        s_next.bresp = scan_regs_pkg::RESP_OKAY;
        // only lane 0 carries register bits
        for (int i = 2; i <= 9; i++) begin
          if (s_reg.w_strb[0] && (wr_idx == 6'(i))) begin
            s_next.regs[i] = s_reg.w_data[7:0] & write_mask(wr_idx); // RULE5 RULE6
          end
        end
      end
    end
    if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      s_next.rresp = scan_regs_pkg::RESP_SLVERR;
      if (is_mapped(S_AXI_ARADDR)) begin
        s_next.rresp = scan_regs_pkg::RESP_OKAY;
        for (int i = 2; i <= 9; i++) begin
          if (rd_idx == 6'(i)) begin
            s_next.rdata = {24'h000000, s_reg.regs[i]};
          end
        end
      end
    end
    // a frame in progress keeps the settings it started with
    if (FRAME_START) begin
      s_next.active.stereo_sequence_select = mode_now[scan_regs_pkg::STEREO_BIT]; // RULE1 RULE10
      s_next.active.scan_type_select = scan_decode(
        mode_now[scan_regs_pkg::SCAN_HI_BIT:scan_regs_pkg::SCAN_LO_BIT]); // RULE2 RULE10
      s_next.active.vertical_direction = mode_now[scan_regs_pkg::VDIR_BIT]; // RULE3
      s_next.active.horizontal_direction = mode_now[scan_regs_pkg::HDIR_BIT]; // RULE4
      s_next.active.top_row_position =
        s_reg.regs[scan_regs_pkg::IDX_TOP][scan_regs_pkg::POS_HI_BIT:0]; // RULE5
      s_next.active.bottom_row_position =
        s_reg.regs[scan_regs_pkg::IDX_BOT][scan_regs_pkg::POS_HI_BIT:0]; // RULE6
    end
    // row reset fires once a row has been lit for twice the duty value in lines
    s_next.row_reset = 1'b0;
    if (FRAME_START) begin
      s_next.line_cnt = '0;
    end else if (LINE_START && (duty_now != 8'h00)) begin
      if ((s_reg.line_cnt + 9'h001) >= duty_lines) begin // RULE7
        s_next.line_cnt = '0;
        s_next.row_reset = 1'b1;
      end else begin
        s_next.line_cnt = s_reg.line_cnt + 9'h001;
      end
    end
    if (s_reg.regs[scan_regs_pkg::IDX_RAMP][scan_regs_pkg::RAMP_HIGH_BIT]) begin
      s_next.ramp_code = 8'hff; // RULE9
    end else begin
      s_next.ramp_code = RAMP_CODE_IN;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_reg <= '0;
      s_reg.regs[scan_regs_pkg::IDX_MODE] <= scan_regs_pkg::MODE_RESET; // RULE1 RULE2
      s_reg.regs[scan_regs_pkg::IDX_TOP] <= scan_regs_pkg::TOP_RESET; // RULE5
      s_reg.regs[scan_regs_pkg::IDX_BOT] <= scan_regs_pkg::BOT_RESET; // RULE6
      s_reg.regs[scan_regs_pkg::IDX_DUTY] <= scan_regs_pkg::DUTY_RESET; // RULE7
      s_reg.regs[scan_regs_pkg::IDX_RAMP] <= scan_regs_pkg::RAMP_RESET; // RULE8 RULE9
      s_reg.regs[scan_regs_pkg::IDX_RAMP_CUR] <= scan_regs_pkg::RAMP_CUR_RESET;
      s_reg.regs[scan_regs_pkg::IDX_VDAC_MAX] <= scan_regs_pkg::VDAC_MAX_RESET;
      s_reg.regs[scan_regs_pkg::IDX_BIAS] <= scan_regs_pkg::BIAS_RESET;
      s_reg.active <= scan_regs_pkg::CFG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign SCAN_CFG = s_reg.active;
  assign ROW_DUTY_EN = (duty_now != 8'h00); // RULE7
  assign ROW_RESET = s_reg.row_reset;
  assign COUNTER_POWER_SAVE =
    s_reg.regs[scan_regs_pkg::IDX_RAMP][scan_regs_pkg::PSAVE_BIT]; // RULE8
  assign RAMP_DAC_CODE = s_reg.ramp_code;
  assign RAMP_CURRENT = s_reg.regs[scan_regs_pkg::IDX_RAMP_CUR];
  assign VDAC_MAX = s_reg.regs[scan_regs_pkg::IDX_VDAC_MAX];
  assign BIAS = s_reg.regs[scan_regs_pkg::IDX_BIAS];

  // helpers read only by the checks below
  logic stereo_now;
  logic scan_hi_now;
  logic vdir_now;
  logic hdir_now;
  logic [5:0] top_now;
  logic [5:0] bot_now;
  logic duty_on;
  logic ramp_high_now;
  logic psave_write;
  logic psave_data;
  logic [1:0] scan_code_now;
  assign stereo_now = mode_now[scan_regs_pkg::STEREO_BIT];
  assign scan_code_now = mode_now[scan_regs_pkg::SCAN_HI_BIT:scan_regs_pkg::SCAN_LO_BIT];
  assign scan_hi_now = mode_now[scan_regs_pkg::SCAN_HI_BIT];
  assign vdir_now = mode_now[scan_regs_pkg::VDIR_BIT];
  assign hdir_now = mode_now[scan_regs_pkg::HDIR_BIT];
  assign top_now = s_reg.regs[scan_regs_pkg::IDX_TOP][5:0];
  assign bot_now = s_reg.regs[scan_regs_pkg::IDX_BOT][5:0];
  assign duty_on = (duty_now != 8'h00);
  assign ramp_high_now = s_reg.regs[scan_regs_pkg::IDX_RAMP][scan_regs_pkg::RAMP_HIGH_BIT];
  // an unaligned address lands on the same index but must not write
  assign psave_write = wr_commit && is_mapped(s_reg.aw_addr) &&
    (wr_idx == scan_regs_pkg::IDX_RAMP) && s_reg.w_strb[0];
  assign psave_data = s_reg.w_data[scan_regs_pkg::PSAVE_BIT];

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  cfg_hold_a: assert property (!FRAME_START |=> $stable(SCAN_CFG)) // RULE10
    else $error("scan settings changed outside frame start");
  stereo_load_a: assert property (FRAME_START |=> // RULE1
    SCAN_CFG.stereo_sequence_select == $past(stereo_now))
    else $error("stereo select not loaded at frame start");
  scan_pseudo_a: assert property (FRAME_START && scan_hi_now |=> // RULE2
    SCAN_CFG.scan_type_select == scan_regs_pkg::SCAN_PSEUDO)
    else $error("upper scan bit did not give pseudo-interlaced");
  scan_inter_a: assert property (FRAME_START && (scan_code_now == 2'b01) |=> // RULE2
    SCAN_CFG.scan_type_select == scan_regs_pkg::SCAN_INTERLACED)
    else $error("interlaced code not decoded");
  scan_prog_a: assert property (FRAME_START && (scan_code_now == 2'b00) |=> // RULE2
    SCAN_CFG.scan_type_select == scan_regs_pkg::SCAN_PROGRESSIVE)
    else $error("progressive code not decoded");
  vdir_load_a: assert property (FRAME_START |=> // RULE3
    SCAN_CFG.vertical_direction == $past(vdir_now))
    else $error("vertical direction not loaded");
  hdir_load_a: assert property (FRAME_START |=> // RULE4
    SCAN_CFG.horizontal_direction == $past(hdir_now))
    else $error("horizontal direction not loaded");
  top_load_a: assert property (FRAME_START |=> // RULE5
    SCAN_CFG.top_row_position == $past(top_now))
    else $error("top row not loaded");
  bot_load_a: assert property (FRAME_START |=> // RULE6
    SCAN_CFG.bottom_row_position == $past(bot_now))
    else $error("bottom row not loaded");

  // the masks keep unused upper bits of the stored settings at zero
  mode_mask_a: assert property (mode_now[7:5] == 3'h0) // RULE1
    else $error("unused mode bits were written");
  pos_mask_a: assert property ( // RULE5 RULE6
    (s_reg.regs[scan_regs_pkg::IDX_TOP][7:6] | s_reg.regs[scan_regs_pkg::IDX_BOT][7:6]) == 2'h0)
    else $error("unused row position bits were written");

  duty_off_a: assert property (ROW_RESET |-> $past(duty_on) && $past(LINE_START)) // RULE7
    else $error("row reset without duty control or line start");
  // a zero duty value must silence the pulse, whatever the line count says
  duty_zero_a: assert property (!duty_on |=> !ROW_RESET) // RULE7
    else $error("row reset while duty control is off");
  row_single_a: assert property (ROW_RESET |=> !ROW_RESET) // RULE7
    else $error("row reset longer than one cycle");
  psave_write_a: assert property (psave_write |=> COUNTER_POWER_SAVE == $past(psave_data)) // RULE8
    else $error("power save bit did not follow write");
  psave_hold_a: assert property (!psave_write |=> $stable(COUNTER_POWER_SAVE)) // RULE8
    else $error("power save bit changed without a write");
  ramp_high_a: assert property (ramp_high_now |=> RAMP_DAC_CODE == 8'hff) // RULE9
    else $error("ramp code not forced high");
  // without the force bit the code is the input delayed by one register
  ramp_pass_a: assert property (!ramp_high_now |=> RAMP_DAC_CODE == $past(RAMP_CODE_IN)) // RULE9
    else $error("ramp code not passed through");

  // registers are one byte wide, so the upper read lanes stay clear
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped before taken");

endmodule : microdisplay_scan_ctrl_regs

/* tb/axil_host.sv */
`timescale 1ns/1ps

module axil_host (
  // clock
  input wire logic clk,
  // write side
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  input wire logic bvalid,
  output logic bready,
  // read side
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  // status
  output logic timeout
);
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    wdata = 32'h0;
    araddr = 8'h00;
    timeout = 1'b0;
  end

  // readies are sampled 1 ns after an edge, where they hold their value until the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic at;
    logic wt;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    #1;
    while ((awvalid || wvalid) && n < 40) begin
      at = awready;
      wt = wready;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      n++;
      #1;
    end
    while (!bvalid && n < 40) begin
      @(posedge clk);
      n++;
      #1;
    end
    @(posedge clk);
    bready <= 1'b0;
    timeout <= (n >= 40);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic at;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    #1;
    while (arvalid && n < 40) begin
      at = arready;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      n++;
      #1;
    end
    while (!rvalid && n < 40) begin
      @(posedge clk);
      n++;
      #1;
    end
    @(posedge clk);
    rready <= 1'b0;
    timeout <= (n >= 40);
  endtask : rd
endmodule : axil_host

/* tb/tb.sv */
`timescale 1ns/1ps

module tb;
  logic clk;
  logic reset;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, to, frame, line, row_en, row_rst, psave;
  logic [7:0] awaddr, araddr, code_in, dac, cur, vmax, bias;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  scan_regs_pkg::scan_cfg_s cfg;
  logic [16:0] exp_cfg;
  logic [7:0] m, t, b, r;
  logic [39:0] rd_q[$];
  logic [39:0] b_q[$];
  int error_cnt, n_compared, rr_base;
  int rr_cnt = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  microdisplay_scan_ctrl_regs dut (.CLK(clk), .RESET(reset),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .FRAME_START(frame), .LINE_START(line), .RAMP_CODE_IN(code_in),
    .SCAN_CFG(cfg), .ROW_DUTY_EN(row_en), .ROW_RESET(row_rst), .COUNTER_POWER_SAVE(psave),
    .RAMP_DAC_CODE(dac), .RAMP_CURRENT(cur), .VDAC_MAX(vmax), .BIAS(bias));

  axil_host host (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .timeout(to));

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic check_rd(input logic [39:0] got, input logic [39:0] exp);
    check(got, exp);
  endtask : check_rd

  task automatic check_wr(input logic [39:0] got, input logic [39:0] exp);
    check(got, exp);
  endtask : check_wr

  task automatic check_cfg(input logic [16:0] got, input logic [16:0] exp);
    check({23'h0, got}, {23'h0, exp});
  endtask : check_cfg

  // settings expected one frame start after mode md and positions tp, bt are written
  function automatic logic [16:0] cfg_of(input logic [7:0] md, input logic [7:0] tp,
      input logic [7:0] bt);
    cfg_of = {md[4], md[3] ? 2'b10 : {1'b0, md[2]}, md[1:0], tp[5:0], bt[5:0]};
  endfunction : cfg_of

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // unmapped indices answer with an error and zero data
  task automatic rd_exp(input int i, input logic [7:0] v);
    if (i < 2 || i > 9) rd_q.push_back({6'h0, 2'h2, 32'h0});
    else rd_q.push_back({8'h0, 24'h0, v});
    host.rd(8'(i * 4));
  endtask : rd_exp

  task automatic wr_exp(input int i, input logic [7:0] d);
    b_q.push_back((i < 2 || i > 9) ? 40'h2 : 40'h0);
    host.wr(8'(i * 4), {24'h0, d});
  endtask : wr_exp

  task automatic pulse(input bit f);
    @(posedge clk);
    if (f) frame <= 1'b1;
    else line <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    line <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse

  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      check_rd({6'h0, rresp, rdata}, rd_q.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      check_wr({38'h0, bresp}, b_q.pop_front());
    if (row_rst === 1'b1) rr_cnt <= rr_cnt + 1;
    if (to === 1'b1) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    frame = 1'b0;
    line = 1'b0;
    code_in = 8'h00;
    error_cnt = 0;
    n_compared = 0;
    rr_base = 0;
    void'($urandom(44507));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    check_cfg(cfg, 17'h0038e);
    // reset values, with an unmapped index on either side
    for (int i = 1; i <= 10; i++) rd_exp(i, (i == 3 || i == 4) ? 8'h0e : 8'h00);
    // random write and read back through the writable masks
    for (int i = 1; i <= 10; i++) begin
      r = 8'($urandom);
      wr_exp(i, r);
      rd_exp(i, r & ((i == 2) ? 8'h1f : (i < 5) ? 8'h3f : 8'hff));
    end
    m = 8'($urandom);
    t = 8'($urandom);
    b = 8'($urandom);
    wr_exp(2, m);
    wr_exp(3, t);
    wr_exp(4, b);
    pulse(1'b1);
    exp_cfg = cfg_of(m, t, b);
    check_cfg(cfg, exp_cfg);
    // every scan code; the old setting must stand until the next frame start
    for (int s = 0; s < 4; s++) begin
      m = 8'($urandom);
      m[3:2] = s[1:0];
      wr_exp(2, m);
      #1;
      check_cfg(cfg, exp_cfg);
      pulse(1'b1);
      exp_cfg = cfg_of(m, t, b);
      check_cfg(cfg, exp_cfg);
    end
    wr_exp(6, 8'h18);
    @(posedge clk);
    #1;
    check({38'h0, psave, 1'b0}, {38'h0, 2'b10});
    check({32'h0, dac}, 40'hff);
    wr_exp(6, 8'h00);
    code_in <= 8'($urandom);
    @(posedge clk);
    #1;
    check({32'h0, dac}, {32'h0, code_in});
    check({39'h0, psave}, 40'h0);
    // duty zero never pulses; otherwise one pulse per 2*duty lines
    for (int d = 0; d < 4; d += 1 + (d > 0)) begin
      wr_exp(5, 8'(d));
      #1;
      check({39'h0, row_en}, {39'h0, d != 0});
      pulse(1'b1);
      rr_base = rr_cnt;
      repeat (12) pulse(1'b0);
      repeat (3) @(posedge clk);
      check(40'(rr_cnt - rr_base), (d == 0) ? 40'h0 : 40'(12 / (2 * d)));
    end
    // a second reset in mid-run must bring back the reset scan settings, mode, duty and power save values
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check_cfg(cfg, 17'h0038e);
    check({37'h0, row_en, psave, row_rst}, 40'h0);
    check({32'h0, dac}, {32'h0, code_in});
    rd_exp(2, 8'h00);
    rd_exp(5, 8'h00);
    repeat (4) @(posedge clk);
    check(40'(rd_q.size() + b_q.size()), 40'h0);
    final_report();
  end
endmodule : tb
